// ==== rtl/cwf_pkg.sv ====
// Shared constants and types for the bus wake-up and fault monitor
package cwf_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int CNT_W = 16;
  localparam int PULSE_MIN_NS = 500;
  localparam int PULSE_MAX_US = 500;
  localparam int GAP_MAX_US = 500;
  localparam int WINDOW_US = 1000;
  localparam int TX_DOM_US = 360;
  localparam int INT_PULSE_US = 1;
  localparam int RST_HOLD_US = 10;
  // Least times round up, longest times round down
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;
  localparam int GAP_MAX_CYC = GAP_MAX_US * CLK_MHZ;
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam int TX_DOM_CYC = TX_DOM_US * CLK_MHZ;
  localparam logic [7:0] INT_PULSE_CYC = 8'(INT_PULSE_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] RST_HOLD_CYC = CNT_W'(RST_HOLD_US * CLK_MHZ);
  localparam logic [1:0] WK_PULSES = 2'h3;
  localparam logic [1:0] STRAP_CYC = 2'h3;

  // ----------------------------------------------------------------
  // Serial command byte: select, read/write, data, MSB first
  // ----------------------------------------------------------------
  localparam int CMD_SEL_W = 3;
  localparam int CMD_DATA_W = 4;
  localparam int CMD_SEL_MSB = 7;
  localparam int CMD_RW_BIT = 4;
  localparam logic [2:0] REG_MODE_CTRL = 3'h0;
  localparam logic [2:0] REG_CAN = 3'h1;
  localparam logic [2:0] REG_IO_STATUS = 3'h2;
  localparam logic [2:0] REG_INT_EN = 3'h3;

  // Field positions
  localparam int MODE_MSB = 1;
  localparam int GENERAL_FAILURE_FLAG_BIT = 3;
  localparam int CAN_SLEEP_BIT = 3;
  localparam int WAKE_EN_BIT = 2;
  localparam int SLEW_MSB = 1;
  localparam int WAKE_FLAG_BIT = 0;
  localparam int OTEMP_BIT = 1;
  localparam int STUCK_BIT = 2;
  localparam int OCUR_BIT = 3;
  localparam int SLOW_BIT = 0;
  localparam int INT_CAN_BIT = 0;
  localparam int INT_SLOW_BIT = 1;

  // Synchroniser lanes
  localparam int SY_TX = 0;
  localparam int SY_BUS = 1;
  localparam int SY_SLOW = 2;
  localparam int SY_UV = 3;
  localparam int SY_OT = 4;
  localparam int SY_OC = 5;
  localparam int SY_BAL = 6;
  localparam int SY_W = 7;

  typedef enum logic [1:0] {
    CHIP_NORMAL = 2'h0,
    CHIP_STANDBY = 2'h1,
    CHIP_STOP = 2'h2,
    CHIP_SLEEP = 2'h3
  } cwf_chip_mode_type;

  typedef enum logic [2:0] {
    WK_IDLE = 3'h1,
    WK_PULSE = 3'h2,
    WK_GAP = 3'h4
  } cwf_wake_state_type;

endpackage

// ==== rtl/cwf_monitor.sv ====
// Bus wake-up pattern detector, fault latches and driver control
// ----------------------------------------------------------------
// Notes on behaviour
// - Sleep without wake-up ignores bus
// - Deep sleep wake: regulator on, then reset
// - Stop mode wake: pulse on interrupt
// - Normal/standby wake sets bus wake flag
// - Wake flag holds until normal plus read
// - Three dominant pulses, 500 ns to 500 us
// - Gaps under 500 us, all within 1 ms
// - Low bus supply flags, interrupts, stops CAN; the code interrupts only with int_en bit 1 set
// - Main undervoltage: reset and supply-low flag; the code does both only with the ballast strap low
// - Transmit low over 360 us disables driver
// - Driver returns when transmit goes high
// - Stuck-dominant flag at D2, clear on read
// - Stuck dominant sets general failure, interrupt; the code interrupts only with int_en bit 0 set
// - Overtemperature disables driver, flags, interrupts; the code interrupts only with int_en bit 0 set
// - Driver returns when temperature drops
// - Overtemperature flag latched, clear on read
// - Overcurrent sets flags, optional interrupt
// - Overcurrent flag latched, clear on read
// - Command: select, read/write, four data bits
// - Transmit low drives dominant, receive mirrors bus
// - Four slew rates, zero after reset
// ----------------------------------------------------------------
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps

module cwf_monitor
  import cwf_pkg::*;
#(
  parameter logic [cwf_pkg::CNT_W-1:0] PULSE_MAX = cwf_pkg::CNT_W'(cwf_pkg::PULSE_MAX_CYC),
  parameter logic [cwf_pkg::CNT_W-1:0] GAP_MAX = cwf_pkg::CNT_W'(cwf_pkg::GAP_MAX_CYC),
  parameter logic [cwf_pkg::CNT_W-1:0] WINDOW = cwf_pkg::CNT_W'(cwf_pkg::WINDOW_CYC),
  parameter logic [cwf_pkg::CNT_W-1:0] TX_DOM = cwf_pkg::CNT_W'(cwf_pkg::TX_DOM_CYC)
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [cwf_pkg::CMD_SEL_W-1:0] cmd_addr,
  input wire logic [cwf_pkg::CMD_DATA_W-1:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [cwf_pkg::CMD_DATA_W-1:0] cmd_rdata,
  input wire logic tx_in,
  input wire logic bus_dominant_in,
  input wire logic supply_low_in,
  input wire logic main_uv_in,
  input wire logic overtemp_in,
  input wire logic overcurrent_in,
  input wire logic ballast_strap,
  output logic driver_enable,
  output logic bus_tx_dominant,
  output logic rx_out,
  output logic [1:0] slew_rate,
  output logic int_n,
  output logic main_regulator_on,
  output logic reset_out_n
);
  import cwf_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic [1:0] st_cnt;
    logic ballast;
    cwf_chip_mode_type chip_mode;
    logic can_sleep;
    logic wake_en;
    logic [1:0] slew;
    logic [1:0] int_en;
    logic wake_flag;
    logic otemp_flag;
    logic stuck_flag;
    logic ocur_flag;
    logic general_failure_flag_flag;
    logic slow_flag;
    logic stuck_act;
    logic [CNT_W-1:0] tx_cnt;
    cwf_wake_state_type wk_state;
    logic [1:0] wk_n;
    logic [CNT_W-1:0] wk_pcnt;
    logic [CNT_W-1:0] wk_gcnt;
    logic [CNT_W-1:0] wk_wcnt;
    logic [7:0] int_cnt;
    logic [CNT_W-1:0] rst_cnt;
    logic main_on;
    logic rst_out;
    logic [CMD_DATA_W-1:0] rdata;
    logic drv_en;
    logic tx_dom;
    logic rx;
    logic int_n;
  } cwf_state_type;

  localparam cwf_state_type STATE_RST = '{
    chip_mode: CHIP_NORMAL,
    wk_state: WK_IDLE,
    main_on: 1'b1,
    int_n: 1'b1,
    default: '0
  };

  cwf_state_type s_reg;
  cwf_state_type s_next;
  logic wk_hit;
  logic wake_in_stop;
  logic supply_ok;
  logic can_run;
  logic dom;
  logic ot;
  logic oc;
  logic fault_evt;
  logic slow_evt;

  function automatic logic cnt_done(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
    cnt_done = (cnt >= lim);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    wk_hit = 1'b0;
    s_next.sync1 = {ballast_strap, overcurrent_in, overtemp_in, main_uv_in,
                    supply_low_in, bus_dominant_in, tx_in};
    s_next.sync2 = s_reg.sync1;
    // Strap is caught only after the synchroniser has filled
    if (s_reg.st_cnt != STRAP_CYC)
    begin
      s_next.st_cnt = s_reg.st_cnt + 2'h1;
      s_next.ballast = s_reg.sync2[SY_BAL];
    end
    dom = s_reg.sync2[SY_BUS];
    ot = s_reg.sync2[SY_OT];
    oc = s_reg.sync2[SY_OC];
    supply_ok = s_reg.ballast ? !s_reg.sync2[SY_SLOW] : !s_reg.sync2[SY_UV];
    can_run = !s_reg.can_sleep && supply_ok && s_reg.main_on && s_reg.rst_out;

    // Permanent dominant watchdog on the transmit input
    if (s_reg.sync2[SY_TX])
    begin
      s_next.tx_cnt = '0;
      s_next.stuck_act = 1'b0;
    end
    else if (can_run)
    begin
      if (cnt_done(s_reg.tx_cnt, TX_DOM))
        s_next.stuck_act = 1'b1;
      else
        s_next.tx_cnt = s_reg.tx_cnt + 1'b1;
    end

    // Wake pattern detector, armed only in CAN sleep with wake-up on
    if (!(s_reg.can_sleep && s_reg.wake_en))
    begin
      s_next.wk_state = WK_IDLE;
      s_next.wk_n = '0;
    end
    else
    begin
      if (s_reg.wk_state != WK_IDLE)
        s_next.wk_wcnt = s_reg.wk_wcnt + 1'b1;
      case (s_reg.wk_state)
        WK_IDLE:
        begin
          if (dom)
          begin
            s_next.wk_state = WK_PULSE;
            s_next.wk_pcnt = CNT_W'(1);
            s_next.wk_wcnt = '0;
            s_next.wk_n = '0;
          end
        end
        WK_PULSE:
        begin
          if (dom)
          begin
            if (cnt_done(s_reg.wk_pcnt, PULSE_MAX))
              s_next.wk_state = WK_IDLE;
            else
              s_next.wk_pcnt = s_reg.wk_pcnt + 1'b1;
          end
          else if (!cnt_done(s_reg.wk_pcnt, CNT_W'(PULSE_MIN_CYC)))
            s_next.wk_state = WK_IDLE;
          else if (s_reg.wk_n == WK_PULSES - 2'h1)
          begin
            wk_hit = 1'b1;
            s_next.wk_state = WK_IDLE;
          end
          else
          begin
            s_next.wk_n = s_reg.wk_n + 2'h1;
            s_next.wk_state = WK_GAP;
            s_next.wk_gcnt = CNT_W'(1);
          end
        end
        WK_GAP:
        begin
          if (dom)
          begin
            s_next.wk_state = WK_PULSE;
            s_next.wk_pcnt = CNT_W'(1);
          end
          else if (cnt_done(s_reg.wk_gcnt, GAP_MAX))
            s_next.wk_state = WK_IDLE;
          else
            s_next.wk_gcnt = s_reg.wk_gcnt + 1'b1;
        end
        default:
        begin
          s_next.wk_state = WK_IDLE;
        end
      endcase
      // Whole pattern must fit the window
      if (s_reg.wk_state != WK_IDLE && cnt_done(s_reg.wk_wcnt, WINDOW))
      begin
        s_next.wk_state = WK_IDLE;
        wk_hit = 1'b0;
      end
    end

    // Register writes
    if (cmd_wr)
    begin
      case (cmd_addr)
        REG_MODE_CTRL: s_next.chip_mode = cwf_chip_mode_type'(cmd_wdata[MODE_MSB:0]);
        REG_CAN:
        begin
          s_next.can_sleep = cmd_wdata[CAN_SLEEP_BIT];
          s_next.wake_en = cmd_wdata[WAKE_EN_BIT];
          s_next.slew = cmd_wdata[SLEW_MSB:0];
        end
        REG_INT_EN: s_next.int_en = cmd_wdata[1:0];
        default: s_next.int_en = s_reg.int_en;
      endcase
    end

    // Wake reporting depends on the power mode at the moment of the hit
    wake_in_stop = wk_hit && (s_reg.chip_mode == CHIP_STOP);
    if (wk_hit && s_reg.chip_mode == CHIP_SLEEP)
    begin
      s_next.main_on = 1'b1;
      s_next.chip_mode = CHIP_NORMAL;
    end
    else if (wake_in_stop)
      s_next.chip_mode = CHIP_NORMAL;
    if (s_next.chip_mode == CHIP_SLEEP)
      s_next.main_on = 1'b0;

    // Reset output: held during regulator off, undervoltage with the ballast strap low, and hold time
    if (!s_next.main_on || (!s_reg.ballast && s_reg.sync2[SY_UV]))
    begin
      s_next.rst_out = 1'b0;
      s_next.rst_cnt = '0;
    end
    else if (cnt_done(s_reg.rst_cnt, RST_HOLD_CYC))
      s_next.rst_out = 1'b1;
    else
      s_next.rst_cnt = s_reg.rst_cnt + 1'b1;

    // Read side effects first, so that a set in the same cycle wins
    if (cmd_rd && cmd_addr == REG_CAN)
    begin
      if (!s_reg.can_sleep)
        s_next.wake_flag = 1'b0;
      if (!ot)
        s_next.otemp_flag = 1'b0;
      if (!s_reg.stuck_act)
        s_next.stuck_flag = 1'b0;
      if (!oc)
        s_next.ocur_flag = 1'b0;
    end
    if (cmd_rd && cmd_addr == REG_MODE_CTRL && !(ot || oc || s_reg.stuck_act))
      s_next.general_failure_flag_flag = 1'b0;
    if (cmd_rd && cmd_addr == REG_IO_STATUS && !supply_ok)
      s_next.slow_flag = s_reg.slow_flag;
    else if (cmd_rd && cmd_addr == REG_IO_STATUS)
      s_next.slow_flag = 1'b0;

    if (wk_hit)
      s_next.wake_flag = 1'b1;
    if (ot)
      s_next.otemp_flag = 1'b1;
    if (s_reg.stuck_act)
      s_next.stuck_flag = 1'b1;
    if (oc)
      s_next.ocur_flag = 1'b1;
    if (ot || oc || s_reg.stuck_act)
      s_next.general_failure_flag_flag = 1'b1;
    if (!supply_ok)
      s_next.slow_flag = 1'b1;

    // Interrupt pulse: enabled fault events and wake in stop mode
    fault_evt = (ot && !s_reg.otemp_flag) || (oc && !s_reg.ocur_flag)
                || (s_reg.stuck_act && !s_reg.stuck_flag);
    slow_evt = !supply_ok && !s_reg.slow_flag;
    if ((fault_evt && s_reg.int_en[INT_CAN_BIT]) || (slow_evt && s_reg.int_en[INT_SLOW_BIT])
        || wake_in_stop)
      s_next.int_cnt = INT_PULSE_CYC;
    else if (s_reg.int_cnt != 8'h00)
      s_next.int_cnt = s_reg.int_cnt - 8'h01;
    s_next.int_n = (s_next.int_cnt == 8'h00);

    // Read data stands for one cycle only
    s_next.rdata = '0;
    if (cmd_rd)
    begin
      case (cmd_addr)
        REG_MODE_CTRL:
        begin
          s_next.rdata[GENERAL_FAILURE_FLAG_BIT] = s_reg.general_failure_flag_flag;
          s_next.rdata[MODE_MSB:0] = s_reg.chip_mode;
        end
        REG_CAN:
        begin
          s_next.rdata[WAKE_FLAG_BIT] = s_reg.wake_flag;
          s_next.rdata[OTEMP_BIT] = s_reg.otemp_flag;
          s_next.rdata[STUCK_BIT] = s_reg.stuck_flag;
          s_next.rdata[OCUR_BIT] = s_reg.ocur_flag;
        end
        REG_IO_STATUS: s_next.rdata[SLOW_BIT] = s_reg.slow_flag;
        REG_INT_EN: s_next.rdata[1:0] = s_reg.int_en;
        default: s_next.rdata = '0;
      endcase
    end

    // Driver and receiver pins
    s_next.drv_en = !s_next.can_sleep && supply_ok && s_next.main_on && s_next.rst_out
                    && !s_next.stuck_act && !ot;
    s_next.tx_dom = s_next.drv_en && !s_reg.sync2[SY_TX];
    // Receiver follows the bus only when running; sleep with supply idles high
    if (!s_next.can_sleep && supply_ok && s_next.rst_out)
      s_next.rx = !dom;
    else
      s_next.rx = supply_ok && s_next.rst_out;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= STATE_RST;
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_rdata = s_reg.rdata;
  assign driver_enable = s_reg.drv_en;
  assign bus_tx_dominant = s_reg.tx_dom;
  assign rx_out = s_reg.rx;
  assign slew_rate = s_reg.slew;
  assign int_n = s_reg.int_n;
  assign main_regulator_on = s_reg.main_on;
  assign reset_out_n = s_reg.rst_out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_wake_needs_arm: assert property ($rose(s_reg.wake_flag) |->
      $past(s_reg.can_sleep) && $past(s_reg.wake_en))
    else $error("wake flag set while detector not armed");

  a_wake_flag_hold: assert property ($fell(s_reg.wake_flag) |->
      $past(cmd_rd) && $past(cmd_addr) == REG_CAN && !$past(s_reg.can_sleep))
    else $error("wake flag cleared without normal mode read");

  a_sleep_wake_pwr: assert property ((wk_hit && s_reg.chip_mode == CHIP_SLEEP) |=>
      s_reg.main_on && !s_reg.rst_out ##1 !s_reg.rst_out)
    else $error("deep sleep wake did not power up before reset release");

  a_stop_wake_int: assert property (wake_in_stop |=> !s_reg.int_n [*3])
    else $error("stop mode wake gave no interrupt pulse");

  a_pulse_min_len: assert property (wk_hit |->
      s_reg.wk_pcnt >= CNT_W'(PULSE_MIN_CYC) && s_reg.wk_wcnt < WINDOW)
    else $error("wake accepted with short pulse or late window");

  a_stuck_limit: assert property ($rose(s_reg.stuck_act) |->
      $past(s_reg.tx_cnt) == TX_DOM && !$past(s_reg.sync2[SY_TX]))
    else $error("stuck dominant raised at wrong count");

  a_stuck_drv_off: assert property (s_reg.stuck_act |=> ##1 !s_reg.drv_en || !s_reg.stuck_act)
    else $error("driver left on during stuck dominant");

  a_stuck_flag_hold: assert property ($fell(s_reg.stuck_flag) |->
      $past(cmd_rd) && $past(cmd_addr) == REG_CAN && !$past(s_reg.stuck_act))
    else $error("stuck flag cleared without read or with fault present");

  a_otemp_flag_hold: assert property ($fell(s_reg.otemp_flag) |->
      $past(cmd_rd) && $past(cmd_addr) == REG_CAN && !$past(ot))
    else $error("overtemp flag cleared without read or with fault present");

  a_ocur_flag_hold: assert property ($fell(s_reg.ocur_flag) |->
      $past(cmd_rd) && $past(cmd_addr) == REG_CAN && !$past(oc))
    else $error("overcurrent flag cleared without read or with fault present");

  a_general_failure_flag_follows: assert property ((ot || oc || s_reg.stuck_act) |=> s_reg.general_failure_flag_flag)
    else $error("general failure not set on fault");

  a_otemp_drv_off: assert property (ot |=> !s_reg.drv_en)
    else $error("driver left on in overtemperature");

endmodule // cwf_monitor

// ==== bench/cwf_can_node.sv ====
// Far-side node model: host transmit pin and wake-up traffic on the bus
`timescale 1ns/1ps

module cwf_can_node
(
  input wire logic clk,
  output logic tx_in,
  output logic bus_dominant
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Transmit has a pull-up and a released bus reads recessive
  initial
  begin
    tx_in = 1'b1;
    bus_dominant = 1'b0;
  end

  // ----------------------------------------------------------------
  // Traffic
  // ----------------------------------------------------------------
  // n dominant pulses of w cycles with recessive gaps of g cycles
  task automatic pattern(input int n, input int w, input int g);
    repeat (n)
    begin
      @(posedge clk);
      bus_dominant <= 1'b1;
      repeat (w) @(posedge clk);
      bus_dominant <= 1'b0;
      repeat (g - 1) @(posedge clk);
    end
  endtask

  // Transmit held dominant for n cycles, then released
  task automatic hold_tx(input int n);
    @(posedge clk);
    tx_in <= 1'b0;
    repeat (n) @(posedge clk);
    tx_in <= 1'b1;
  endtask
endmodule // cwf_can_node

// ==== bench/cwf_monitor_tb.sv ====
// Self-checking bench for the bus wake-up and fault monitor
`timescale 1ns/1ps

module cwf_monitor_tb;
  import cwf_pkg::*;
  localparam int TXD = 50;
  logic clk = 1'b0;
  logic rst_n;
  logic [2:0] cmd_addr;
  logic [3:0] cmd_wdata;
  logic cmd_wr;
  logic cmd_rd;
  logic [3:0] cmd_rdata;
  logic tx_in;
  logic bus_dom;
  logic supply_low_in;
  logic main_uv_in;
  logic overtemp_in;
  logic overcurrent_in;
  logic ballast_strap;
  logic driver_enable;
  logic bus_tx_dominant;
  logic rx_out;
  logic [1:0] slew_rate;
  logic int_n;
  logic main_regulator_on;
  logic reset_out_n;
  int mismatches = 0;
  int comparisons = 0;
  int int_lo = 0;
  int int_mark = 0;
  int m_flags = 0;
  int m_cond = 0;
  int m_gf = 0;
  int m_mode = 0;
  int m_sleep = 0;
  logic [31:0] seed = 32'h4E8FCB07;

  cwf_monitor #(.PULSE_MAX(16'h0064), .GAP_MAX(16'h0064), .WINDOW(16'h012C),
    .TX_DOM(16'h0032)) dut (.clk(clk), .rst_n(rst_n), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .tx_in(tx_in), .bus_dominant_in(bus_dom), .supply_low_in(supply_low_in),
    .main_uv_in(main_uv_in), .overtemp_in(overtemp_in), .overcurrent_in(overcurrent_in),
    .ballast_strap(ballast_strap), .driver_enable(driver_enable),
    .bus_tx_dominant(bus_tx_dominant), .rx_out(rx_out), .slew_rate(slew_rate),
    .int_n(int_n), .main_regulator_on(main_regulator_on), .reset_out_n(reset_out_n));

  cwf_can_node node (.clk(clk), .tx_in(tx_in), .bus_dominant(bus_dom));

  always #20 clk = ~clk;

  always @(posedge clk)
    if (int_n === 1'b0)
      int_lo <= int_lo + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int rnd(input int span);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % 32'(span));
  endfunction

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Byte fields travel in parallel: select, direction as strobe, nibble
  task automatic wr(input logic [2:0] a, input logic [3:0] d);
    @(posedge clk);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input int exp, input string nm);
    @(posedge clk);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge clk);
    cmd_rd <= 1'b0;
    #1;
    check(nm, {4'h0, cmd_rdata}, 8'(exp));
  endtask

  // Model: a read clears latched bits whose cause is gone; wake bit only out of sleep
  task automatic rd_can();
    rd(REG_CAN, m_flags, "can_flags");
    m_flags = m_cond | ((m_sleep != 0) ? (m_flags & 1) : 0);
  endtask

  task automatic rd_mode();
    rd(REG_MODE_CTRL, m_gf * 8 + m_mode, "mode_ctrl");
    m_gf = (m_cond != 0) ? 1 : 0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic wake_case(input int mode, input logic [3:0] canw, input int w, input int g,
    input int hit);
    wr(REG_CAN, canw);
    m_sleep = canw[3];
    rd_can();
    wr(REG_MODE_CTRL, 4'(mode));
    m_mode = mode;
    settle(5);
    if (mode == 3)
      check("main_off", {7'h0, main_regulator_on}, 8'h00);
    int_mark = int_lo;
    node.pattern(3, w, g);
    settle(40);
    m_flags |= hit;
    if (hit != 0 && mode >= 2)
      m_mode = 0;
    if (mode == 3)
    begin
      check("main_on", {7'h0, main_regulator_on}, 8'(hit));
      check("rst_hold", {7'h0, reset_out_n}, 8'h00);
      wait_rst(400);
    end
    else
      check("int_low", 8'(int_lo - int_mark), (hit != 0 && mode == 2) ? INT_PULSE_CYC : 8'h00);
    rd_mode();
    rd_can();
    rd_can();
    wr(REG_CAN, 4'h0);
    m_sleep = 0;
    rd_can();
    rd_can();
    $display("Test wake mode %0d width %0d gap %0d done", mode, w, g);
  endtask

  task automatic fault_case(input int k);
    logic [3:0] b;
    b = (k == 0) ? 4'h4 : (k == 1) ? 4'h2 : 4'h8;
    int_mark = int_lo;
    // Stuck detection needs the limit plus the synchroniser, then a whole interrupt pulse;
    // transmit stays low past the checks so the driver is still seen off
    if (k == 0)
      fork
        node.hold_tx(TXD + 50);
      join_none
    else if (k == 1)
      overtemp_in <= 1'b1;
    else
      overcurrent_in <= 1'b1;
    settle(TXD + 40);
    m_cond = b;
    m_flags |= b;
    m_gf = 1;
    if (k != 2)
      check("drv_off", {7'h0, driver_enable}, 8'h00);
    check("int_low", 8'(int_lo - int_mark), INT_PULSE_CYC);
    rd_mode();
    rd_can();
    rd_can();
    overtemp_in <= 1'b0;
    overcurrent_in <= 1'b0;
    settle(20);
    m_cond = 0;
    check("drv_on", {7'h0, driver_enable}, 8'h01);
    rd_can();
    rd_can();
    rd_mode();
    rd_mode();
    $display("Test fault %0d done", k);
  endtask

  task automatic wait_rst(input int lim);
    int n;
    n = 0;
    while (reset_out_n !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("reset_out_n", {7'h0, reset_out_n}, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  int cm[8] = '{0, 0, 0, 0, 0, 1, 2, 3};
  int cwd[8] = '{20, 10, 110, 20, 90, 0, 0, 0};
  int cgp[8] = '{20, 20, 20, 120, 90, 0, 0, 0};
  int s;

  initial
  begin
    rst_n = 1'b0;
    cmd_addr = 3'h0;
    cmd_wdata = 4'h0;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    supply_low_in = 1'b0;
    main_uv_in = 1'b0;
    overtemp_in = 1'b0;
    overcurrent_in = 1'b0;
    ballast_strap = 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    check("slew_rst", {6'h0, slew_rate}, 8'h00);
    check("int_idle", {7'h0, int_n}, 8'h01);
    wait_rst(300);
    rd(3'h5, 0, "unmapped");
    wr(3'h6, 4'hF);
    rd(3'h6, 0, "unmapped");
    s = rnd(4);
    wr(REG_CAN, 4'(s));
    settle(2);
    check("slew", {6'h0, slew_rate}, 8'(s));
    fork
      node.hold_tx(12);
    join_none
    settle(8);
    check("tx_dom", {7'h0, bus_tx_dominant}, 8'h01);
    fork
      node.pattern(1, 20, 2);
    join_none
    settle(8);
    check("rx_dom", {7'h0, rx_out}, 8'h00);
    settle(30);
    check("rx_rec", {7'h0, rx_out}, 8'h01);
    $display("Test pins done");
    for (int i = 0; i < 8; i++)
      wake_case(cm[i], (i == 0) ? 4'h8 : 4'hC, (i < 5) ? cwd[i] : 15 + rnd(40),
        (i < 5) ? cgp[i] : 15 + rnd(40), (i < 5) ? 0 : 1);
    wr(REG_INT_EN, 4'h3);
    for (int k = 0; k < 3; k++)
      fault_case(k);
    int_mark = int_lo;
    supply_low_in <= 1'b1;
    // Long enough for the whole interrupt pulse to be counted
    settle(30);
    check("drv_low_sup", {7'h0, driver_enable}, 8'h00);
    check("int_sup", 8'(int_lo - int_mark), INT_PULSE_CYC);
    rd(REG_IO_STATUS, 1, "io_status");
    rd(REG_IO_STATUS, 1, "io_status");
    supply_low_in <= 1'b0;
    settle(10);
    rd(REG_IO_STATUS, 1, "io_status");
    rd(REG_IO_STATUS, 0, "io_status");
    $display("Test supply done");
    // Second reset with the strap low: bus supply follows the main regulator
    ballast_strap <= 1'b0;
    rst_n <= 1'b0;
    settle(4);
    rst_n <= 1'b1;
    wait_rst(300);
    main_uv_in <= 1'b1;
    settle(5);
    check("uv_rst", {7'h0, reset_out_n}, 8'h00);
    check("uv_drv", {7'h0, driver_enable}, 8'h00);
    main_uv_in <= 1'b0;
    wait_rst(300);
    rd(REG_IO_STATUS, 1, "io_status");
    rd(REG_IO_STATUS, 0, "io_status");
    $display("Test undervoltage done");
    results();
  end

  initial
  begin
    #(40 * 40000);
    mismatches++;
    results();
  end
endmodule // cwf_monitor_tb
